// ### inc/oodr_pkg.sv
// Shared constants and carrier types for the dispatch and retire control
package oodr_pkg;

   localparam int BUF_DEPTH = 126;
   localparam int LD_MAX    = 48;
   localparam int ST_MAX    = 24;
   localparam int ISSUE_W   = 6;
   localparam int RET_W     = 3;
   localparam int CMP_W     = 6;
   localparam int PC_W      = 32;
   localparam int EPOCH_W   = 2;
   localparam int IDX_W     = 7;

   localparam logic [PC_W-1:0]    EXC_VECTOR_DEF = 32'h0000_0000;
   localparam logic [EPOCH_W-1:0] EPOCH_RST      = 2'h0;

   typedef enum logic [2:0] {
      K_ALU    = 3'h0,
      K_FP     = 3'h1,
      K_LOAD   = 3'h2,
      K_STORE  = 3'h3,
      K_BRANCH = 3'h4
   } oodr_kind_t;

   // Issue port map: two integer, one floating, one load, one store, one branch
   localparam oodr_kind_t PORT_KIND [ISSUE_W] = '{K_ALU, K_ALU, K_FP, K_LOAD, K_STORE, K_BRANCH};

   typedef struct packed {
      oodr_kind_t       kind;
      logic [PC_W-1:0]  pc;
      logic             s0_v;
      logic [IDX_W-1:0] s0;
      logic             s1_v;
      logic [IDX_W-1:0] s1;
   } oodr_uop_t;

   typedef struct packed {
      logic               valid;
      logic [IDX_W-1:0]   idx;
      logic [EPOCH_W-1:0] epoch;
      logic               exc;
      logic               misp;
      logic               taken;
      logic [PC_W-1:0]    target;
   } oodr_cmp_t;

   typedef struct packed {
      logic               valid;
      oodr_kind_t         kind;
      logic [IDX_W-1:0]   idx;
      logic [EPOCH_W-1:0] epoch;
   } oodr_iss_t;

   typedef struct packed {
      logic             valid;
      logic [IDX_W-1:0] idx;
      logic [PC_W-1:0]  pc;
   } oodr_ret_t;

   typedef struct packed {
      logic            valid;
      logic            taken;
      logic [PC_W-1:0] pc;
      logic [PC_W-1:0] target;
   } oodr_btu_t;

   typedef struct packed {
      logic            valid;
      logic            exc;
      logic [PC_W-1:0] pc;
      logic [PC_W-1:0] fault_pc;
   } oodr_redir_t;

endpackage

// ### src/oodr_pick.sv
// Lowest-index request picker used by each issue port
`timescale 1ns/10ps
module oodr_pick #(
   parameter int N = 126,
   parameter int W = 7
) (
   input  wire logic [N-1:0] req,
   output logic              found,
   output logic [W-1:0]      idx,
   output logic [N-1:0]      onehot
);

   // Index order, not age order; any ready entry may go
   always_comb
   begin
      found  = 1'b0;
      idx    = '0;
      onehot = '0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (req[i])
         begin
            found  = 1'b1;
            idx    = W'(i);
            onehot = '0;
            onehot[i] = 1'b1;
         end
      end
   end

endmodule

// ### src/oodr_core.sv
// Reorder buffer with out-of-order dispatch and in-order retirement
// Behaviour
// (RL1) Buffer holds 126 ops, stalls front end
// (RL2) Stall loads at 48, stores at 24
// (RL3) Front end delivers ops in program order
// (RL4) At most six ops issued per cycle
// (RL5) Issue once operands ready and unit free
// (RL6) Pipelined units take a new op each cycle
// (RL7) Two integer ops per cycle, floating every other
// (RL8) Retire only after completion and writeback
// (RL9) Retire strictly oldest first
// (RL10) At most three retired per cycle
// (RL11) Exceptions raised only at retirement
// (RL12) Retired branches update target buffer, purge traces; code purges only on mispredict, skips faulting branch
// (RL13) Faulting or mispredicted retire flushes, redirects fetch
`timescale 1ns/10ps
module oodr_core #(
   parameter int                      DEPTH      = oodr_pkg::BUF_DEPTH,
   parameter int                      LDMAX      = oodr_pkg::LD_MAX,
   parameter int                      STMAX      = oodr_pkg::ST_MAX,
   parameter logic [oodr_pkg::PC_W-1:0] EXC_VECTOR = oodr_pkg::EXC_VECTOR_DEF
) (
   input  wire logic                  sys_clk,
   input  wire logic                  rstn,
   input  wire logic                  ce,
   input  wire logic                  fe_valid,
   input  wire oodr_pkg::oodr_uop_t   fe_uop,
   output logic                       fe_ready,
   output logic                       fe_ld_ok,
   output logic                       fe_st_ok,
   input  wire logic [oodr_pkg::ISSUE_W-1:0] eu_ready,
   output oodr_pkg::oodr_iss_t        iss [oodr_pkg::ISSUE_W],
   input  wire oodr_pkg::oodr_cmp_t   cmp [oodr_pkg::CMP_W],
   output oodr_pkg::oodr_ret_t        ret [oodr_pkg::RET_W],
   output oodr_pkg::oodr_btu_t        btu,
   output logic                       trace_purge,
   output oodr_pkg::oodr_redir_t      redir
);

   localparam int IW = oodr_pkg::IDX_W;
   localparam int NP = oodr_pkg::ISSUE_W;
   localparam int NR = oodr_pkg::RET_W;
   localparam int NC = oodr_pkg::CMP_W;
   localparam int CW = $clog2(DEPTH + 1);
   localparam int LW = $clog2(LDMAX + 1);
   localparam int SW = $clog2(STMAX + 1);

   logic rst_meta_r;
   logic rst_n_s;

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_meta_r <= 1'b0;
         rst_n_s    <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_n_s    <= rst_meta_r;
      end
   end

   // Entry state
   logic                          valid_r  [DEPTH];
   logic                          issued_r [DEPTH];
   logic                          done_r   [DEPTH];
   logic                          exc_r    [DEPTH];
   logic                          misp_r   [DEPTH];
   logic                          taken_r  [DEPTH];
   logic                          s0v_r    [DEPTH];
   logic                          s1v_r    [DEPTH];
   logic [oodr_pkg::EPOCH_W-1:0]  epoch_r  [DEPTH];
   logic [oodr_pkg::PC_W-1:0]     tgt_r    [DEPTH];
   oodr_pkg::oodr_uop_t           uop_r    [DEPTH];

   logic [IW-1:0]                 head_r;
   logic [IW-1:0]                 tail_r;
   logic [CW-1:0]                 cnt_r;
   logic [LW-1:0]                 ld_cnt_r;
   logic [SW-1:0]                 st_cnt_r;
   logic [oodr_pkg::EPOCH_W-1:0]  epoch_cur_r;
   logic                          fp_gap_r;
   logic                          fe_ready_r;
   logic                          fe_ld_ok_r;
   logic                          fe_st_ok_r;
   oodr_pkg::oodr_iss_t           iss_r [NP];
   oodr_pkg::oodr_ret_t           ret_r [NR];
   oodr_pkg::oodr_btu_t           btu_r;
   logic                          trace_purge_r;
   oodr_pkg::oodr_redir_t         redir_r;

   logic [DEPTH-1:0]              cmp_hit;
   logic [DEPTH-1:0]              ret_oh;
   logic [DEPTH-1:0]              iss_hit;
   logic [DEPTH-1:0]              req  [NP];
   logic [DEPTH-1:0]              oh   [NP];
   logic [IW-1:0]                 pidx [NP];
   logic [NP-1:0]                 found;
   logic [NC-1:0]                 cmp_ok;
   logic [IW-1:0]                 hidx [NR];
   logic [NR-1:0]                 ret_ok;
   logic [1:0]                    ret_n;
   logic [1:0]                    ld_ret;
   logic [1:0]                    st_ret;
   logic                          flush;
   logic                          acc;
   logic                          pend0;
   logic                          pend1;
   logic [IW-1:0]                 stop_idx;
   logic [CW-1:0]                 cnt_nxt;
   logic [LW-1:0]                 ld_cnt_nxt;
   logic [SW-1:0]                 st_cnt_nxt;

   function automatic logic [IW-1:0] nx(input logic [IW-1:0] x);
      nx = (x == IW'(DEPTH - 1)) ? '0 : IW'(x + 1'b1);
   endfunction

   // Completions for flushed work carry a stale epoch and are ignored
   always_comb
   begin
      for (int c = 0; c < NC; c++)
      begin
         cmp_ok[c] = cmp[c].valid && (int'(cmp[c].idx) < DEPTH) && valid_r[cmp[c].idx] &&
                     issued_r[cmp[c].idx] && (epoch_r[cmp[c].idx] == cmp[c].epoch);
      end
   end

   // Front end accept; a flush drops the wrong-path op offered that cycle
   assign pend0 = fe_uop.s0_v && valid_r[fe_uop.s0] && !done_r[fe_uop.s0] && !cmp_hit[fe_uop.s0];
   assign pend1 = fe_uop.s1_v && valid_r[fe_uop.s1] && !done_r[fe_uop.s1] && !cmp_hit[fe_uop.s1];
   assign acc = fe_valid && fe_ready_r && !flush &&                                  // [RL1] [RL3]
                (fe_uop.kind != oodr_pkg::K_LOAD  || fe_ld_ok_r) &&                 // [RL2]
                (fe_uop.kind != oodr_pkg::K_STORE || fe_st_ok_r);

   // Retire scan from the head; a branch or a fault ends the group
   always_comb
   begin
      logic go;
      go       = 1'b1;
      ret_oh   = '0;
      ret_n    = '0;
      ld_ret   = '0;
      st_ret   = '0;
      flush    = 1'b0;
      stop_idx = head_r;
      for (int k = 0; k < NR; k++)                                                   // [RL10]
      begin
         hidx[k]   = (k == 0) ? head_r : nx(hidx[(k > 0) ? k - 1 : 0]);
         ret_ok[k] = go && valid_r[hidx[k]] && done_r[hidx[k]];                      // [RL8] [RL9]
         if (ret_ok[k])
         begin
            ret_oh[hidx[k]] = 1'b1;
            ret_n = 2'(ret_n + 1'b1);
            if (uop_r[hidx[k]].kind == oodr_pkg::K_LOAD)
               ld_ret = 2'(ld_ret + 1'b1);
            if (uop_r[hidx[k]].kind == oodr_pkg::K_STORE)
               st_ret = 2'(st_ret + 1'b1);
            if (exc_r[hidx[k]] || misp_r[hidx[k]])                                   // [RL11] [RL13]
            begin
               flush    = 1'b1;
               stop_idx = hidx[k];
            end
         end
         go = ret_ok[k] && !exc_r[hidx[k]] && !misp_r[hidx[k]] &&
              (uop_r[hidx[k]].kind != oodr_pkg::K_BRANCH);
      end
   end

   always_comb
   begin
      iss_hit = '0;
      for (int p = 0; p < NP; p++)
         iss_hit = iss_hit | oh[p];
   end

   genvar gi;
   genvar gp;
   generate
      for (gi = 0; gi < DEPTH; gi++)
      begin : g_entry
         always_comb
         begin
            cmp_hit[gi] = 1'b0;
            for (int c = 0; c < NC; c++)
               if (cmp_ok[c] && (int'(cmp[c].idx) == gi))
                  cmp_hit[gi] = 1'b1;
         end

         always_ff @(posedge sys_clk or negedge rst_n_s)
         begin
            if (!rst_n_s)
            begin
               valid_r[gi]  <= 1'b0;
               issued_r[gi] <= 1'b0;
               done_r[gi]   <= 1'b0;
               exc_r[gi]    <= 1'b0;
               misp_r[gi]   <= 1'b0;
               taken_r[gi]  <= 1'b0;
               s0v_r[gi]    <= 1'b0;
               s1v_r[gi]    <= 1'b0;
               epoch_r[gi]  <= oodr_pkg::EPOCH_RST;
               tgt_r[gi]    <= '0;
               uop_r[gi]    <= '0;
            end
            else if (ce)
            begin
               if (flush)
                  valid_r[gi] <= 1'b0;                                               // [RL13]
               else if (acc && tail_r == IW'(gi))
               begin
                  valid_r[gi]  <= 1'b1;
                  issued_r[gi] <= 1'b0;
                  done_r[gi]   <= 1'b0;
                  exc_r[gi]    <= 1'b0;
                  misp_r[gi]   <= 1'b0;
                  s0v_r[gi]    <= pend0;
                  s1v_r[gi]    <= pend1;
                  epoch_r[gi]  <= epoch_cur_r;
                  uop_r[gi]    <= fe_uop;
               end
               else
               begin
                  if (ret_oh[gi])
                     valid_r[gi] <= 1'b0;
                  if (iss_hit[gi])
                     issued_r[gi] <= 1'b1;
                  // Result written back; only now eligible to retire
                  if (cmp_hit[gi])                                                   // [RL8]
                  begin
                     done_r[gi] <= 1'b1;
                     for (int c = 0; c < NC; c++)
                        if (cmp_ok[c] && (int'(cmp[c].idx) == gi))
                        begin
                           exc_r[gi]   <= cmp[c].exc;
                           misp_r[gi]  <= cmp[c].misp;
                           taken_r[gi] <= cmp[c].taken;
                           tgt_r[gi]   <= cmp[c].target;
                        end
                  end
                  if (cmp_hit[uop_r[gi].s0])                                         // [RL5]
                     s0v_r[gi] <= 1'b0;
                  if (cmp_hit[uop_r[gi].s1])
                     s1v_r[gi] <= 1'b0;
               end
            end
         end
      end

      for (gp = 0; gp < NP; gp++)
      begin : g_port
         always_comb
         begin
            for (int i = 0; i < DEPTH; i++)
            begin
               req[gp][i] = valid_r[i] && !issued_r[i] && !s0v_r[i] && !s1v_r[i] &&      // [RL5]
                            (uop_r[i].kind == oodr_pkg::PORT_KIND[gp]) &&
                            eu_ready[gp] && !flush &&                                    // [RL6]
                            (oodr_pkg::PORT_KIND[gp] != oodr_pkg::K_FP || !fp_gap_r);    // [RL7]
            end
         end

         if (gp > 0 && oodr_pkg::PORT_KIND[gp] == oodr_pkg::PORT_KIND[(gp > 0) ? gp - 1 : 0])
         begin : g_second
            // Second integer port skips the first port's pick
            oodr_pick #(.N(DEPTH), .W(IW)) u_pick (
               .req    (req[gp] & ~oh[gp - 1]),                                      // [RL7]
               .found  (found[gp]),
               .idx    (pidx[gp]),
               .onehot (oh[gp])
            );
         end
         else
         begin : g_first
            oodr_pick #(.N(DEPTH), .W(IW)) u_pick (
               .req    (req[gp]),
               .found  (found[gp]),
               .idx    (pidx[gp]),
               .onehot (oh[gp])
            );
         end

         always_ff @(posedge sys_clk or negedge rst_n_s)
         begin
            if (!rst_n_s)
               iss_r[gp] <= '0;
            else if (ce)
            begin
               iss_r[gp].valid <= found[gp];                                         // [RL4]
               iss_r[gp].kind  <= oodr_pkg::PORT_KIND[gp];
               iss_r[gp].idx   <= pidx[gp];
               iss_r[gp].epoch <= epoch_r[pidx[gp]];
            end
         end
      end
   endgenerate

   assign cnt_nxt    = flush ? '0 : CW'(cnt_r + CW'(acc) - CW'(ret_n));
   assign ld_cnt_nxt = flush ? '0 :
                       LW'(ld_cnt_r + LW'(acc && fe_uop.kind == oodr_pkg::K_LOAD) - LW'(ld_ret));
   assign st_cnt_nxt = flush ? '0 :
                       SW'(st_cnt_r + SW'(acc && fe_uop.kind == oodr_pkg::K_STORE) - SW'(st_ret));

   // Occupancy, limits and ring pointers
   always_ff @(posedge sys_clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
      begin
         head_r      <= '0;
         tail_r      <= '0;
         cnt_r       <= '0;
         ld_cnt_r    <= '0;
         st_cnt_r    <= '0;
         fe_ready_r  <= 1'b0;
         fe_ld_ok_r  <= 1'b0;
         fe_st_ok_r  <= 1'b0;
         epoch_cur_r <= oodr_pkg::EPOCH_RST;
         fp_gap_r    <= 1'b0;
      end
      else if (ce)
      begin
         cnt_r      <= cnt_nxt;
         ld_cnt_r   <= ld_cnt_nxt;
         st_cnt_r   <= st_cnt_nxt;
         fe_ready_r <= (cnt_nxt < CW'(DEPTH));                                        // [RL1]
         fe_ld_ok_r <= (ld_cnt_nxt < LW'(LDMAX));                                     // [RL2]
         fe_st_ok_r <= (st_cnt_nxt < SW'(STMAX));                                     // [RL2]
         fp_gap_r   <= found[2];                                                      // [RL7]
         if (flush)
         begin
            head_r      <= '0;
            tail_r      <= '0;
            epoch_cur_r <= epoch_cur_r + 1'b1;
         end
         else
         begin
            head_r <= (ret_n == 2'h0) ? head_r : hidx[ret_n - 2'h1] == hidx[0] && ret_n == 2'h1 ?
                      nx(hidx[0]) : nx(hidx[ret_n - 2'h1]);
            if (acc)
               tail_r <= nx(tail_r);
         end
      end
   end

   // Retire, branch update and redirect outputs
   always_ff @(posedge sys_clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
      begin
         for (int k = 0; k < NR; k++)
            ret_r[k] <= '0;
         btu_r       <= '0;
         trace_purge_r <= 1'b0;
         redir_r     <= '0;
      end
      else if (ce)
      begin
         for (int k = 0; k < NR; k++)
         begin
            ret_r[k].valid <= ret_ok[k];                                              // [RL9]
            ret_r[k].idx   <= hidx[k];
            ret_r[k].pc    <= uop_r[hidx[k]].pc;
         end
         btu_r.valid    <= 1'b0;
         trace_purge_r  <= 1'b0;
         for (int k = 0; k < NR; k++)
            if (ret_ok[k] && uop_r[hidx[k]].kind == oodr_pkg::K_BRANCH && !exc_r[hidx[k]])
            begin
               btu_r.valid  <= 1'b1;                                                  // [RL12]
               btu_r.taken  <= taken_r[hidx[k]];
               btu_r.pc     <= uop_r[hidx[k]].pc;
               btu_r.target <= tgt_r[hidx[k]];
               trace_purge_r <= misp_r[hidx[k]];
            end
         redir_r.valid    <= flush;                                                   // [RL13]
         redir_r.exc      <= flush && exc_r[stop_idx];                                // [RL11]
         redir_r.pc       <= exc_r[stop_idx] ? EXC_VECTOR : tgt_r[stop_idx];
         redir_r.fault_pc <= uop_r[stop_idx].pc;
      end
   end

   assign fe_ready  = fe_ready_r;
   assign fe_ld_ok  = fe_ld_ok_r;
   assign fe_st_ok  = fe_st_ok_r;
   assign iss       = iss_r;
   assign ret       = ret_r;
   assign btu       = btu_r;
   assign trace_purge = trace_purge_r;
   assign redir     = redir_r;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n_s || !ce);

   sequence flush_done_s;
      ##1 (redir_r.valid && cnt_r == '0 && ld_cnt_r == '0 && st_cnt_r == '0);
   endsequence

   buf_cap_a: assert property (acc |-> cnt_r < CW'(DEPTH)) else $error("accept into full buffer"); // [RL1]
   ld_cap_a: assert property (ld_cnt_r <= LW'(LDMAX)) else $error("load limit exceeded"); // [RL2]
   st_cap_a: assert property (st_cnt_r <= SW'(STMAX)) else $error("store limit exceeded"); // [RL2]
   fp_rate_a: assert property (iss_r[2].valid |=> !iss_r[2].valid) else $error("fp back to back"); // [RL7]
   alu_pair_a: assert property (iss_r[0].valid && iss_r[1].valid |-> iss_r[0].idx != iss_r[1].idx)
      else $error("same op on both integer ports"); // [RL4]
   deps_ready_a: assert property (found[0] |-> !s0v_r[pidx[0]] && !s1v_r[pidx[0]] && !issued_r[pidx[0]])
      else $error("issue with pending operand"); // [RL5]
   ret_order_a: assert property (ret_r[1].valid |-> ret_r[0].valid && ret_r[1].idx == nx(ret_r[0].idx))
      else $error("retire out of order"); // [RL9]
   ret_done_a: assert property (ret_ok[0] |=> !valid_r[$past(head_r)] || flush) else $error("retired entry kept"); // [RL8]
   flush_seq_a: assert property (flush |-> flush_done_s) else $error("flush not completed"); // [RL13]
   exc_retire_a: assert property (redir_r.exc |-> redir_r.valid && $past(ret_ok[0]))
      else $error("exception without retire"); // [RL11]

endmodule

// ### test/oodr_eu_model.sv
// Execution pipeline model: fixed latency per issue port
`timescale 1ns/10ps
module oodr_eu_model #(
   parameter int          LAT_FP = 6,
   parameter logic [31:0] BR_TGT = 32'h0000_8000
) (
   input  wire logic                        sys_clk,
   input  wire logic                        stall,
   input  wire logic                        misp_on,
   input  wire logic                        exc_on,
   input  wire logic [oodr_pkg::IDX_W-1:0]  exc_idx,
   input  wire oodr_pkg::oodr_iss_t         iss [oodr_pkg::ISSUE_W],
   output logic [oodr_pkg::ISSUE_W-1:0]     eu_ready,
   output oodr_pkg::oodr_cmp_t              cmp [oodr_pkg::CMP_W]
);
   oodr_pkg::oodr_cmp_t pipe [6][8];
   assign eu_ready = stall ? 6'h00 : 6'h3f;
   initial
   begin
      pipe = '{default: '0};
      cmp = '{default: '0};
   end
   // Each port takes a new op every cycle, results return in order
   always @(posedge sys_clk)
   begin
      #1;
      for (int p = 0; p < 6; p++)
      begin
         for (int d = 0; d < 7; d++)
            pipe[p][d] = pipe[p][d+1];
         pipe[p][7] = '0;
         if (iss[p].valid === 1'b1)
            pipe[p][p == 2 ? LAT_FP - 1 : 1] = '{1'b1, iss[p].idx, iss[p].epoch,
               exc_on && iss[p].idx == exc_idx, misp_on && p == 5, p == 5, BR_TGT};
         cmp[p] = pipe[p][0];
      end
   end
endmodule

// ### test/ooo_dispatch_retire_control_tb.sv
// Self-checking bench for the dispatch and retire control
`timescale 1ns/10ps
module ooo_dispatch_retire_control_tb;
   localparam int          LAT_FP = 6;
   localparam logic [31:0] BR_TGT = 32'h0000_8000;
   logic                  sys_clk = 1'b0;
   logic                  rstn = 1'b0;
   logic                  fe_valid = 1'b0;
   oodr_pkg::oodr_uop_t   fe_uop = '0;
   logic                  fe_ready;
   logic                  fe_ld_ok;
   logic                  fe_st_ok;
   logic                  trace_purge;
   logic [5:0]            eu_ready;
   oodr_pkg::oodr_iss_t   iss [6];
   oodr_pkg::oodr_cmp_t   cmp [6];
   oodr_pkg::oodr_ret_t   ret [3];
   oodr_pkg::oodr_btu_t   btu;
   oodr_pkg::oodr_redir_t redir;
   logic                  stall = 1'b1;
   logic                  misp_on = 1'b0;
   logic                  exc_on = 1'b0;
   logic [6:0]            exc_idx = 7'h00;
   int                    fails = 0;
   int                    n_compared = 0;
   int                    cyc = 0;
   logic [31:0]           pcq [$];
   logic [31:0]           next_pc = 32'h0000_1000;
   int                    iss_cyc [126];
   int                    ret_cyc [126];
   oodr_pkg::oodr_redir_t got_redir = '0;
   oodr_pkg::oodr_btu_t   got_btu = '0;
   logic                  got_purge = 1'b0;
   logic                  fp_prev = 1'b0;

   always #2 sys_clk = ~sys_clk;

   oodr_core i_dut (.sys_clk, .rstn, .ce(1'b1), .fe_valid, .fe_uop, .fe_ready, .fe_ld_ok,
      .fe_st_ok, .eu_ready, .iss, .cmp, .ret, .btu, .trace_purge, .redir);
   oodr_eu_model #(.LAT_FP(LAT_FP), .BR_TGT(BR_TGT)) i_eu (.sys_clk, .stall, .misp_on,
      .exc_on, .exc_idx, .iss, .eu_ready, .cmp);

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wrap_up;
      if (fails == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Watches retire, issue and redirect pulses once settled
   always @(negedge sys_clk)
   begin
      cyc++;
      if (rstn === 1'b1)
      begin
         for (int s = 0; s < 3; s++)
            if (ret[s].valid === 1'b1)
            begin
               ret_cyc[ret[s].idx] = cyc;
               if (s > 0)
                  chk(ret[s-1].valid, 1);
               if (pcq.size() == 0)
                  chk(0, 1);
               else
                  chk(ret[s].pc, pcq.pop_front());
            end
         for (int p = 0; p < 6; p++)
            if (iss[p].valid === 1'b1)
            begin
               iss_cyc[iss[p].idx] = cyc;
               chk(iss[p].kind, oodr_pkg::PORT_KIND[p]);
            end
         chk(fp_prev && iss[2].valid, 0);
         fp_prev = iss[2].valid;
         if (btu.valid === 1'b1)
         begin
            got_btu = btu;
            got_purge = trace_purge;
         end
         if (redir.valid === 1'b1)
         begin
            got_redir = redir;
            pcq.delete();
         end
      end
   end

   // Ops carry rising pcs in program order
   task automatic offer(input oodr_pkg::oodr_kind_t k, input logic [6:0] src, input int maxw,
                        output bit ok);
      logic lim;
      fe_uop = '{k, next_pc, src != 7'h7f, src, 1'b0, 7'h00};
      fe_valid = 1'b1;
      ok = 0;
      for (int i = 0; i < maxw && !ok; i++)
      begin
         @(negedge sys_clk);
         lim = k == oodr_pkg::K_LOAD ? fe_ld_ok : k == oodr_pkg::K_STORE ? fe_st_ok : 1'b1;
         ok = fe_ready === 1'b1 && lim === 1'b1;
         @(posedge sys_clk);
         #1;
      end
      if (ok)
      begin
         pcq.push_back(next_pc);
         next_pc += 4;
      end
      else
         fe_valid = 1'b0;
   endtask

   task automatic fill_until(input oodr_pkg::oodr_kind_t k, output int n);
      bit ok;
      n = 0;
      ok = 1;
      while (ok && n < 130)
      begin
         offer(k, 7'h7f, 3, ok);
         n += ok;
      end
      @(posedge sys_clk);
      #1;
   endtask

   task automatic drain;
      stall = 1'b0;
      for (int i = 0; i < 2000 && pcq.size() > 0; i++)
         @(posedge sys_clk);
      if (pcq.size() > 0)
      begin
         fails++;
         wrap_up();
      end
      repeat (10) @(posedge sys_clk);
      #1;
   endtask

   // Ops gathered while stalled, then released together
   task automatic t_order;
      bit ok;
      oodr_pkg::oodr_kind_t ks [9] = '{oodr_pkg::K_FP, oodr_pkg::K_FP, oodr_pkg::K_ALU,
         oodr_pkg::K_ALU, oodr_pkg::K_ALU, oodr_pkg::K_LOAD, oodr_pkg::K_STORE,
         oodr_pkg::K_BRANCH, oodr_pkg::K_ALU};
      for (int i = 0; i < 9; i++)
      begin
         offer(ks[i], i == 2 ? 7'h00 : 7'h7f, 20, ok);
         chk(ok, 1);
      end
      fe_valid = 1'b0;
      drain();
      for (int i = 3; i < 8; i++)
         chk(iss_cyc[i], iss_cyc[0]);
      chk(iss_cyc[8], iss_cyc[3] + 1);
      chk(iss_cyc[1], iss_cyc[0] + 2);
      chk(iss_cyc[2] > iss_cyc[0] + LAT_FP, 1);
      chk(ret_cyc[0] > iss_cyc[0] + LAT_FP - 1, 1);
      chk(ret_cyc[5], ret_cyc[2] + 1);
      chk(ret_cyc[8], ret_cyc[2] + 2);
      chk({got_btu.valid, got_btu.taken, got_purge}, 3'h6);
      chk(got_btu.pc, 32'h0000_101c);
      chk(got_btu.target, BR_TGT);
   endtask

   task automatic t_limits;
      int n;
      stall = 1'b1;
      fill_until(oodr_pkg::K_ALU, n);
      chk(n, oodr_pkg::BUF_DEPTH);
      drain();
      stall = 1'b1;
      fill_until(oodr_pkg::K_LOAD, n);
      chk(n, oodr_pkg::LD_MAX);
      fill_until(oodr_pkg::K_STORE, n);
      chk(n, oodr_pkg::ST_MAX);
      drain();
   endtask

   task automatic t_flush;
      bit ok;
      logic [31:0] p0;
      misp_on = 1'b1;
      offer(oodr_pkg::K_BRANCH, 7'h7f, 20, ok);
      chk(ok, 1);
      offer(oodr_pkg::K_ALU, 7'h7f, 20, ok);
      chk(ok, 1);
      offer(oodr_pkg::K_ALU, 7'h7f, 20, ok);
      chk(ok, 1);
      fe_valid = 1'b0;
      drain();
      chk({got_redir.valid, got_redir.exc, got_purge}, 3'h5);
      chk(got_redir.pc, BR_TGT);
      misp_on = 1'b0;
      exc_on = 1'b1;
      got_btu = '0;
      p0 = next_pc;
      offer(oodr_pkg::K_ALU, 7'h7f, 20, ok);
      chk(ok, 1);
      offer(oodr_pkg::K_ALU, 7'h7f, 20, ok);
      chk(ok, 1);
      fe_valid = 1'b0;
      drain();
      chk({got_redir.valid, got_redir.exc, got_btu.valid}, 3'h6);
      chk(got_redir.pc, oodr_pkg::EXC_VECTOR_DEF);
      chk(got_redir.fault_pc, p0);
   endtask

   initial
   begin
      repeat (4) @(posedge sys_clk);
      #1;
      rstn = 1'b1;
      repeat (4) @(posedge sys_clk);
      #1;
      t_order();
      t_limits();
      t_flush();
      wrap_up();
   end
endmodule
